// file: design/thermal_readout_pkg.sv
// Shared constants and carrier types for the temperature readout block.
// Assumes one 40 MHz clock; all users reference names as package::name.
package thermal_readout_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register pointers
    localparam logic [7:0] PTR_RESULT = 8'h05; // Temperature result, read only
    localparam logic [7:0] PTR_MAKER = 8'h06; // Maker code, read only
    localparam logic [7:0] PTR_PART = 8'h07; // Part and revision code, read only
    localparam logic [7:0] PTR_RES = 8'h08; // Resolution select

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int CRIT_BIT = 15; // Critical flag
    localparam int HIGH_BIT = 14; // Upper-limit flag
    localparam int LOW_BIT = 13; // Lower-limit flag
    localparam int RES_FIELD_LSB = 3; // Resolution field sits in bits 4:3
    localparam logic [1:0] RES_RESET = 2'h1; // 0.25 degree LSB after reset
    localparam logic [2:0] RES_LOW_ONES = 3'h7; // Low bits always read as ones
    localparam logic [15:0] RESULT_RESET = 16'h0000; // Result before first load

    // Masks that clear fraction bits finer than the selected LSB
    localparam logic [15:0] MASK_HALF = 16'hfff8;
    localparam logic [15:0] MASK_QUARTER = 16'hfffc;
    localparam logic [15:0] MASK_EIGHTH = 16'hfffe;
    localparam logic [15:0] MASK_SIXTEENTH = 16'hffff;

    // Hysteresis in 0.25 degree steps: 0, 1.5, 3 and 6 degrees
    localparam logic [12:0] HYST_0 = 13'h0000;
    localparam logic [12:0] HYST_1 = 13'h0006;
    localparam logic [12:0] HYST_2 = 13'h000c;
    localparam logic [12:0] HYST_3 = 13'h0018;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam longint CONV_TIME_NS = 100_000_000; // Longest conversion, 100 ms
    localparam longint CLK_PERIOD_NS = 25; // 40 MHz clock
    // Longest time rounds down to whole cycles
    localparam int CONV_CYCLES = int'(CONV_TIME_NS / CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic ptr_load; // Pulse: new pointer byte arrived
        logic [7:0] ptr; // Pointer byte
        logic byte_rd; // Pulse: host clocks out one data byte
        logic wr_en; // Pulse: host wrote a full word to ptr
        logic [15:0] wr_data; // Written word
    } reg_req_t;

    typedef struct packed {
        logic valid; // Pulse: conversion finished
        logic [12:0] code; // Sign plus 12 bits, 0.0625 degree LSB
    } sample_t;

    typedef struct packed {
        logic [12:0] high; // Upper limit, result bit layout
        logic [12:0] low; // Lower limit
        logic [12:0] crit; // Critical limit
        logic [1:0] hyst_sel; // Hysteresis code
    } limits_t;

    typedef struct packed {
        logic crit; // Above critical limit
        logic high; // Above upper limit
        logic low; // Below lower limit
    } flags_t;

endpackage

// file: design/limit_flag_eval.sv
// Combinational limit comparators with hysteresis for the three status flags.
// Assumes limits and temperature share the result bit layout (two's complement).
`timescale 1ns/10ps
module limit_flag_eval (
    input wire logic [12:0] temp,
    input wire thermal_readout_pkg::limits_t limits,
    input wire thermal_readout_pkg::flags_t flags_prev,
    output thermal_readout_pkg::flags_t flags_next
);

    ////////////////////////////////////////////////////////////////////////////
    // Comparison values in 0.25 degree steps, two sign bits of headroom
    logic signed [12:0] t_s; // Temperature, bits 12:2 extended
    logic signed [12:0] high_s; // Upper limit
    logic signed [12:0] low_s; // Lower limit
    logic signed [12:0] crit_s; // Critical limit
    logic signed [12:0] hyst_s; // Hysteresis

    // Finer bits are dropped so a fine resolution cannot move the flags
    always_comb begin
        t_s = signed'({{2{temp[12]}}, temp[12:2]});
        high_s = signed'({{2{limits.high[12]}}, limits.high[12:2]});
        low_s = signed'({{2{limits.low[12]}}, limits.low[12:2]});
        crit_s = signed'({{2{limits.crit[12]}}, limits.crit[12:2]});
        case (limits.hyst_sel)
            2'h0: hyst_s = signed'(thermal_readout_pkg::HYST_0);
            2'h1: hyst_s = signed'(thermal_readout_pkg::HYST_1);
            2'h2: hyst_s = signed'(thermal_readout_pkg::HYST_2);
            default: hyst_s = signed'(thermal_readout_pkg::HYST_3);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag update: set condition, clear condition, otherwise hold
    always_comb begin
        flags_next = flags_prev;
        // Critical: set above limit, clear below limit minus hysteresis
        if (t_s > crit_s) begin
            flags_next.crit = 1'b1;
        end else if (t_s < crit_s - hyst_s) begin
            flags_next.crit = 1'b0;
        end
        // Upper: set above limit, clear at or below limit minus hysteresis
        if (t_s > high_s) begin
            flags_next.high = 1'b1;
        end else if (t_s <= high_s - hyst_s) begin
            flags_next.high = 1'b0;
        end
        // Lower: set below limit minus hysteresis, clear at or above limit
        if (t_s < low_s - hyst_s) begin
            flags_next.low = 1'b1;
        end else if (t_s >= low_s) begin
            flags_next.low = 1'b0;
        end
    end

endmodule

// file: design/temp_result_status_id_regs.sv
// Temperature result, status flags, identity codes and resolution select.
// Assumes a serial engine on the same clock hands over pointer and byte pulses,
// and the converter and limit logic sit on the same clock too.
`timescale 1ns/10ps

// How it works
// - Read-only result word at pointer 05
// - Fraction bits finer than resolution read zero
// - Critical flag sets above, clears below hysteresis
// - Upper flag clears at limit minus hysteresis
// - Lower flag sets below limit minus hysteresis
// - Result bits share the limit bit layout
// - Fixed maker code at pointer 06
// - Part byte and revision at pointer 07
// - Resolution select bits 4:3, ones below
// - Reset resolution is 0.25 degree, reads 000f
// - Resolution mirrored out to capability field
// - Conversion started within every 100 ms
// - Temperatures are two's complement
// - Flags compare only bits 12 to 2
// - Power-down stops conversions and result updates
module temp_result_status_id_regs #(
    parameter logic [15:0] MAKER_CODE = 16'h1234, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] REVISION = 8'h01, // Arbitrary value
    parameter int CONV_CYCLES = thermal_readout_pkg::CONV_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_en,
    input wire thermal_readout_pkg::reg_req_t req,
    input wire thermal_readout_pkg::sample_t sample,
    input wire thermal_readout_pkg::limits_t limits,
    input wire logic power_down_bit,
    output logic [7:0] rd_byte_q,
    output logic rd_valid_q,
    output logic [1:0] lsb_size_field_q,
    output thermal_readout_pkg::flags_t flags_q,
    output logic conv_start_q
);

    localparam int TW = $clog2(CONV_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Result register and status flags
    logic [15:0] result_q; // Flags plus temperature
    logic [15:0] result_d;
    thermal_readout_pkg::flags_t flags_d;
    thermal_readout_pkg::flags_t flags_eval; // Comparator outcome for new sample
    logic load; // Conversion result accepted

    limit_flag_eval limit_flag_eval_i (
        .temp(sample.code),
        .limits(limits),
        .flags_prev(flags_q),
        .flags_next(flags_eval)
    );

    // A powered-down sensor keeps its last word and raises no new events
    assign load = sample.valid && !power_down_bit;

    // Flags and temperature go in on the same edge, so no read sees a mix
    always_comb begin
        result_d = result_q;
        flags_d = flags_q;
        if (load) begin
            flags_d = flags_eval;
            result_d = {flags_eval.crit, flags_eval.high, flags_eval.low,
                        sample.code};
        end
    end

    // Register the result group
    always_ff @(posedge clock) begin
        if (reset) begin
            result_q <= thermal_readout_pkg::RESULT_RESET;
            flags_q <= '0;
        end else if (clock_en) begin
            result_q <= result_d;
            flags_q <= flags_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion timer
    logic [TW-1:0] timer_q; // Cycles since last start
    logic [TW-1:0] timer_d;
    logic conv_start_d;

    // Start a conversion once per period; power-down parks the timer
    always_comb begin
        timer_d = timer_q;
        conv_start_d = 1'b0;
        if (power_down_bit) begin
            timer_d = '0;
        end else if (timer_q >= TW'(CONV_CYCLES - 1)) begin
            timer_d = '0;
            conv_start_d = 1'b1;
        end else begin
            timer_d = timer_q + TW'(1);
        end
    end

    // Register the timer group
    always_ff @(posedge clock) begin
        if (reset) begin
            timer_q <= '0;
            conv_start_q <= 1'b0;
        end else if (clock_en) begin
            timer_q <= timer_d;
            conv_start_q <= conv_start_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register access: pointer, resolution, two-byte reads
    typedef enum logic {PH_MSB, PH_LSB} byte_phase_t;
    byte_phase_t phase_q; // Which byte comes next
    byte_phase_t phase_d;
    logic [7:0] ptr_q; // Current pointer
    logic [7:0] ptr_d;
    logic [7:0] snap_low_q; // Low byte held from the high-byte read
    logic [7:0] snap_low_d;
    logic [7:0] rd_byte_d;
    logic rd_valid_d;
    logic [1:0] res_d;
    logic [15:0] frac_mask; // Clears bits below selected LSB
    logic [15:0] read_word; // Word addressed by the pointer

    // Read multiplexer; unmapped pointers read as zero
    always_comb begin
        case (lsb_size_field_q)
            2'h0: frac_mask = thermal_readout_pkg::MASK_HALF;
            2'h1: frac_mask = thermal_readout_pkg::MASK_QUARTER;
            2'h2: frac_mask = thermal_readout_pkg::MASK_EIGHTH;
            default: frac_mask = thermal_readout_pkg::MASK_SIXTEENTH;
        endcase
        case (ptr_q)
            thermal_readout_pkg::PTR_RESULT: read_word = result_q & frac_mask;
            thermal_readout_pkg::PTR_MAKER: read_word = MAKER_CODE;
            thermal_readout_pkg::PTR_PART: read_word = {PART_CODE, REVISION};
            thermal_readout_pkg::PTR_RES: read_word = {11'h000, lsb_size_field_q,
                thermal_readout_pkg::RES_LOW_ONES};
            default: read_word = 16'h0000;
        endcase
    end

    // The whole word is captured at the high byte so both bytes match
    always_comb begin
        ptr_d = ptr_q;
        phase_d = phase_q;
        snap_low_d = snap_low_q;
        rd_byte_d = rd_byte_q;
        rd_valid_d = 1'b0;
        res_d = lsb_size_field_q;
        if (req.ptr_load) begin
            ptr_d = req.ptr;
            phase_d = PH_MSB;
        end else if (req.byte_rd) begin
            rd_valid_d = 1'b1;
            if (phase_q == PH_MSB) begin
                rd_byte_d = read_word[15:8];
                snap_low_d = read_word[7:0];
                phase_d = PH_LSB;
            end else begin
                rd_byte_d = snap_low_q;
                phase_d = PH_MSB;
            end
        end
        // Only the resolution word is writable; other words ignore writes
        if (req.wr_en && req.ptr == thermal_readout_pkg::PTR_RES) begin
            res_d = req.wr_data[thermal_readout_pkg::RES_FIELD_LSB +: 2];
        end
    end

    // Register the access group
    always_ff @(posedge clock) begin
        if (reset) begin
            ptr_q <= 8'h00;
            phase_q <= PH_MSB;
            snap_low_q <= 8'h00;
            rd_byte_q <= 8'h00;
            rd_valid_q <= 1'b0;
            lsb_size_field_q <= thermal_readout_pkg::RES_RESET;
        end else if (clock_en) begin
            ptr_q <= ptr_d;
            phase_q <= phase_d;
            snap_low_q <= snap_low_d;
            rd_byte_q <= rd_byte_d;
            rd_valid_q <= rd_valid_d;
            lsb_size_field_q <= res_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_RESULT_LOAD: assert property (
        clock_en && load |=> result_q[12:0] == $past(sample.code))
        else $error("result does not hold the loaded sample");

    AST_FRAC_ZERO: assert property (
        ptr_q == thermal_readout_pkg::PTR_RESULT && lsb_size_field_q == 2'h0
        |-> read_word[2:0] == 3'h0)
        else $error("fraction bits finer than resolution not zero");

    AST_CRIT_SET: assert property (
        clock_en && load && $signed(sample.code[12:2]) > $signed(limits.crit[12:2])
        |=> result_q[thermal_readout_pkg::CRIT_BIT] && flags_q.crit)
        else $error("critical flag not set above limit");

    AST_HIGH_CLEAR: assert property (
        clock_en && load && limits.hyst_sel == 2'h0
        && $signed(sample.code[12:2]) <= $signed(limits.high[12:2])
        |=> !result_q[thermal_readout_pkg::HIGH_BIT])
        else $error("upper flag not cleared at limit with no hysteresis");

    AST_LOW_CLEAR: assert property (
        clock_en && load && $signed(sample.code[12:2]) >= $signed(limits.low[12:2])
        |=> !result_q[thermal_readout_pkg::LOW_BIT])
        else $error("lower flag not cleared at or above limit");

    AST_RES_MIRROR: assert property (
        clock_en && req.wr_en && req.ptr == thermal_readout_pkg::PTR_RES
        |=> lsb_size_field_q == $past(req.wr_data[thermal_readout_pkg::RES_FIELD_LSB +: 2]))
        else $error("resolution write not mirrored");

    AST_RES_RESET: assert property (
        $fell(reset) |-> lsb_size_field_q == thermal_readout_pkg::RES_RESET)
        else $error("resolution not at 0.25 degree after reset");

    // A missed start would leave the sensor silent, so the period end is checked
    AST_CONV_PERIOD: assert property (
        clock_en && !power_down_bit && timer_q == TW'(CONV_CYCLES - 1)
        |=> conv_start_q && timer_q == '0)
        else $error("conversion not started at the end of its period");

    AST_PDOWN_HOLD: assert property (
        power_down_bit |=> $stable(result_q) && !conv_start_q)
        else $error("result changed or conversion started in power-down");

    AST_BYTE_PAIR: assert property (
        clock_en && req.byte_rd && !req.ptr_load && phase_q == PH_MSB
        ##1 clock_en && req.byte_rd && !req.ptr_load
        |=> rd_valid_q && rd_byte_q == $past(snap_low_q))
        else $error("second byte differs from captured low byte");

    COV_CRIT: cover property (clock_en && load && flags_eval.crit);
    COV_RES_WRITE: cover property (clock_en && req.wr_en
        && req.ptr == thermal_readout_pkg::PTR_RES);
    COV_TWO_BYTES: cover property (rd_valid_q && phase_q == PH_LSB ##1 rd_valid_q);
    COV_CONV: cover property (conv_start_q);

endmodule

// file: dv/host_model.sv
// Host side of the register port: pointer loads, byte reads and word writes.
// Assumes the block samples requests on the rising clock edge.
`timescale 1ns/10ps
module host_model (
    input wire logic clock,
    output thermal_readout_pkg::reg_req_t req
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        req = '0;
    end

    // Pointer, then two bytes high first; gap stalls the host between bytes
    task automatic read_word(input logic [7:0] ptr, input int gap);
        @(posedge clock);
        req.ptr_load <= 1'b1;
        req.ptr <= ptr;
        @(posedge clock);
        req.ptr_load <= 1'b0;
        req.ptr <= ~ptr; // Released pointer is not left at its old value
        req.byte_rd <= 1'b1;
        @(posedge clock);
        if (gap > 0) begin
            req.byte_rd <= 1'b0;
            repeat (gap) @(posedge clock);
            req.byte_rd <= 1'b1;
        end
        @(posedge clock);
        req.byte_rd <= 1'b0;
    endtask

    // Whole word write, held for exactly the edge that takes it
    task automatic write_word(input logic [7:0] ptr, input logic [15:0] data);
        @(posedge clock);
        req.wr_en <= 1'b1;
        req.ptr <= ptr;
        req.wr_data <= data;
        @(posedge clock);
        req.wr_en <= 1'b0;
        req.ptr <= ~ptr;
        req.wr_data <= ~data; // Stale data must not look valid
    endtask
endmodule

// file: dv/temp_result_status_id_regs_tb.sv
// Self-checking bench for the result, identity and resolution registers.
// Assumes host_model drives the register port; bytes are checked from a queue.
`timescale 1ns/10ps
module temp_result_status_id_regs_tb;
    localparam int CONV_N = 16; // Short conversion period keeps the run brief
    localparam logic [15:0] MAKER = 16'h2a5c; // Arbitrary value
    localparam logic [7:0] PART = 8'h3c; // Arbitrary value
    localparam logic [7:0] REV = 8'h07; // Arbitrary value
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic clock_en = 1'b1; // Dropped once, to check the freeze of the timer
    logic power_down_bit = 1'b0;
    thermal_readout_pkg::reg_req_t req;
    thermal_readout_pkg::sample_t sample = '0;
    thermal_readout_pkg::limits_t limits = '0;
    logic [7:0] rd_byte_q;
    logic rd_valid_q;
    logic [1:0] lsb_size_field_q;
    thermal_readout_pkg::flags_t flags_q;
    logic conv_start_q;
    int n_mismatch = 0;
    int check_count = 0;
    integer seed = 32'hbecb1c72;
    logic [7:0] exp_q[$]; // Expected bytes in order of return
    thermal_readout_pkg::flags_t m_flags = '0; // Reference flag state
    logic [12:0] m_code = '0; // Reference temperature
    int n;

    always #12.5 clock = ~clock;

    temp_result_status_id_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART), .REVISION(REV),
        .CONV_CYCLES(CONV_N)) temp_result_status_id_regs_i (.clock(clock), .reset(reset),
        .clock_en(clock_en), .req(req), .sample(sample), .limits(limits),
        .power_down_bit(power_down_bit), .rd_byte_q(rd_byte_q), .rd_valid_q(rd_valid_q),
        .lsb_size_field_q(lsb_size_field_q), .flags_q(flags_q), .conv_start_q(conv_start_q));
    host_model host_model_i (.clock(clock), .req(req));

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Fraction bits finer than the selected LSB are cleared on read
    function automatic logic [15:0] res_mask(input logic [1:0] r);
        case (r)
            2'h0: return thermal_readout_pkg::MASK_HALF;
            2'h1: return thermal_readout_pkg::MASK_QUARTER;
            2'h2: return thermal_readout_pkg::MASK_EIGHTH;
            default: return thermal_readout_pkg::MASK_SIXTEENTH;
        endcase
    endfunction

    // Flag update with hysteresis, on quarter-degree bits only
    function automatic thermal_readout_pkg::flags_t next_flags(input logic [12:0] code,
        input thermal_readout_pkg::flags_t prev);
        thermal_readout_pkg::flags_t f;
        logic signed [11:0] t, h, l, c, hy;
        f = prev;
        t = {code[12], code[12:2]};
        h = {limits.high[12], limits.high[12:2]};
        l = {limits.low[12], limits.low[12:2]};
        c = {limits.crit[12], limits.crit[12:2]};
        case (limits.hyst_sel)
            2'h0: hy = thermal_readout_pkg::HYST_0[11:0];
            2'h1: hy = thermal_readout_pkg::HYST_1[11:0];
            2'h2: hy = thermal_readout_pkg::HYST_2[11:0];
            default: hy = thermal_readout_pkg::HYST_3[11:0];
        endcase
        if (t > c) f.crit = 1'b1;
        else if (t < c - hy) f.crit = 1'b0;
        if (t > h) f.high = 1'b1;
        else if (t <= h - hy) f.high = 1'b0;
        if (t < l - hy) f.low = 1'b1;
        else if (t >= l) f.low = 1'b0;
        return f;
    endfunction

    // Note both expected bytes, then let the host read the word
    task automatic expect_read(input logic [7:0] ptr, input logic [15:0] word, input int gap);
        exp_q.push_back(word[15:8]);
        exp_q.push_back(word[7:0]);
        host_model_i.read_word(ptr, gap);
        for (int i = 0; i < 8 && exp_q.size() > 0; i++) @(posedge clock);
    endtask

    // One conversion result; dropped by the reference while powered down
    task automatic put_sample(input logic [12:0] code);
        @(posedge clock);
        sample <= {1'b1, code};
        @(posedge clock);
        sample <= {1'b0, ~code};
        if (!power_down_bit) begin
            m_flags = next_flags(code, m_flags);
            m_code = code;
        end
        #1 check("flags", {13'h0, flags_q}, {13'h0, m_flags});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Byte monitor: every returned byte consumes the oldest note
    always @(posedge clock) begin
        if (!reset && rd_valid_q === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("rd_extra", {8'h00, rd_byte_q}, 16'hxxxx);
            end else begin
                check("rd_byte", {8'h00, rd_byte_q}, {8'h00, exp_q.pop_front()});
            end
        end
    end

    // Watchdog sized well above the expected run
    initial begin
        #(25 * 30000);
        n_mismatch++;
        $display("watchdog expired");
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        check("lsb_size", {14'h0, lsb_size_field_q}, 16'h0001);
        expect_read(thermal_readout_pkg::PTR_RES, 16'h000f, 0);
        expect_read(thermal_readout_pkg::PTR_MAKER, MAKER, 2);
        expect_read(thermal_readout_pkg::PTR_PART, {PART, REV}, 0);
        expect_read(8'h09, 16'h0000, 1);
        expect_read(thermal_readout_pkg::PTR_RESULT, 16'h0000, 0);
        $display("test reset_and_ids done");
        limits <= {13'h0280, 13'h00a0, 13'h0500, 2'h0};
        for (int r = 0; r < 4; r++) begin
            host_model_i.write_word(thermal_readout_pkg::PTR_RES,
                16'($random(seed)) & 16'hffe7 | 16'(r << 3));
            #1 check("lsb_size", {14'h0, lsb_size_field_q}, 16'(r));
            expect_read(thermal_readout_pkg::PTR_RES, {11'h0, 2'(r), 3'h7}, 0);
            put_sample(13'($random(seed) % 1920));
            expect_read(thermal_readout_pkg::PTR_RESULT, {m_flags, m_code} & res_mask(2'(r)),
                0);
        end
        host_model_i.write_word(thermal_readout_pkg::PTR_RESULT, 16'hffff);
        expect_read(thermal_readout_pkg::PTR_RESULT, {m_flags, m_code}, 0);
        $display("test resolution done");
        for (int hs = 0; hs < 4; hs++) begin
            limits.hyst_sel <= 2'(hs);
            put_sample(13'h0283); // Fraction above limit must not raise high
            put_sample(13'h0284);
            put_sample(13'h0501);
            for (int k = 0; k < 10; k++) begin
                put_sample(13'($random(seed) % 1920));
                expect_read(thermal_readout_pkg::PTR_RESULT, {m_flags, m_code}, 0);
            end
        end
        $display("test flags done");
        power_down_bit <= 1'b1;
        put_sample(13'h0123);
        expect_read(thermal_readout_pkg::PTR_RESULT, {m_flags, m_code}, 0);
        n = 0;
        repeat (3 * CONV_N) begin
            @(posedge clock);
            n += int'(conv_start_q === 1'b1);
        end
        check("starts_off", 16'(n), 16'h0000);
        power_down_bit <= 1'b0;
        for (int i = 0; i < 2 * CONV_N + 4 && conv_start_q !== 1'b1; i++) @(posedge clock);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (conv_start_q !== 1'b1 && n < 2 * CONV_N);
        check("start_gap", 16'(n), 16'(CONV_N));
        // Freeze right after a start: no pulse, and frozen cycles do not count
        clock_en <= 1'b0;
        n = 0;
        repeat (2 * CONV_N) begin
            @(posedge clock);
            n += int'(conv_start_q === 1'b1);
        end
        check("starts_frozen", 16'(n), 16'h0000);
        clock_en <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (conv_start_q !== 1'b1 && n < 2 * CONV_N);
        check("gap_after_freeze", 16'(n), 16'(CONV_N));
        $display("test power_and_conversion done");
        report_and_stop();
    end
endmodule
